// *** hdl/sfsp_data_mem.sv ***
/*
  Internal 256-byte data memory with one synchronous write port and
  one asynchronous read port. Assumes the caller serialises accesses.
*/
`timescale 1ns/1ns
module sfsp_data_mem #(
  parameter int unsigned DEPTH = sfsp_pkg::MEM_DEPTH
) (
  // Clock
  input  wire logic       i_clock,
  // Write port
  input  wire logic       i_we,
  input  wire logic [7:0] i_waddr,
  input  wire logic [7:0] i_wdata,
  // Read port
  input  wire logic [7:0] i_raddr,
  output logic      [7:0] o_rdata
);

  logic [7:0] mem [DEPTH];

  // Write; no reset, contents are undefined at power up
  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Read is combinational so push and pop finish in one cycle
  assign o_rdata = mem[i_raddr];

endmodule : sfsp_data_mem

// *** hdl/sfsp_pkg.sv ***
/*
  Package for the special function space and stack pointer block:
  register addresses, reset values, bit-access layout, access types.
  Assumes a single 8-bit internal address space shared by data memory
  and special function registers, split by addressing mode.
*/
package sfsp_pkg;

  // Address and data widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Data memory depth, full 256 bytes
  localparam int unsigned MEM_DEPTH = 256;

  // Boundary between lower memory and the special function space
  localparam logic [7:0] SFS_BASE = 8'h80;

  // Register addresses in the special function space
  localparam logic [7:0] ADR_STACK_TOP = 8'h81;
  localparam logic [7:0] ADR_DPTR_LO   = 8'h82;
  localparam logic [7:0] ADR_DPTR_HI   = 8'h83;
  localparam logic [7:0] ADR_STATUS    = 8'hD0;
  localparam logic [7:0] ADR_ARITH_A   = 8'hE0;
  localparam logic [7:0] ADR_ARITH_B   = 8'hF0;

  // Reset values
  localparam logic [7:0] RST_STACK_TOP = 8'h07;
  localparam logic [7:0] RST_DPTR_LO   = 8'h00;
  localparam logic [7:0] RST_DPTR_HI   = 8'h00;
  localparam logic [7:0] RST_STATUS    = 8'h00;
  localparam logic [7:0] RST_ARITH_A   = 8'h00;
  localparam logic [7:0] RST_ARITH_B   = 8'h00;

  // Bit address layout: upper five bits pick the column-aligned register
  localparam int unsigned BIT_SEL_W   = 3;
  localparam logic [2:0]  COLUMN_ZERO = 3'h0;

  // Lower memory bytes that also answer to bit addresses start here
  localparam logic [7:0] BIT_MEM_BASE = 8'h20;

  // Value read from a reserved address
  localparam logic [7:0] RD_RESERVED = 8'h00;

  // Kind of access from the core
  typedef enum logic [2:0] {
    SFSP_REQ_NONE,
    SFSP_REQ_DIRECT,
    SFSP_REQ_INDIRECT,
    SFSP_REQ_BIT,
    SFSP_REQ_PUSH,
    SFSP_REQ_POP
  } sfsp_kind_t;

  // One request from the core
  typedef struct packed {
    sfsp_kind_t  kind;
    logic        write;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wbit;
  } sfsp_req_t;

  // One answer to the core
  typedef struct packed {
    logic        valid;
    logic [7:0]  rdata;
    logic        rbit;
  } sfsp_rsp_t;

endpackage : sfsp_pkg

// *** hdl/sfsp_space.sv ***
/*
  Special function space decoder with the stack pointer and the core
  registers it holds, plus the 256-byte data memory. Assumes the core
  issues at most one request per clock, on the same clock, and keeps
  away from reserved addresses.
*/
`timescale 1ns/1ns
module sfsp_space (
  // Clock and reset
  input  wire logic                i_clock,
  input  wire logic                i_nrst,
  // Core request and answer
  input  wire sfsp_pkg::sfsp_req_t i_req,
  output sfsp_pkg::sfsp_rsp_t      o_rsp,
  // Register views for the core
  output logic [7:0]               o_stack_top_pointer,
  output logic [15:0]              o_data_pointer,
  output logic [7:0]               o_processor_status_flags,
  output logic [7:0]               o_arith_primary_reg,
  output logic [7:0]               o_arith_secondary_reg,
  // Flags a rejected access
  output logic                     o_access_error
);

  ////////////////////////////////////////////////////////////////////
  // Reset synchroniser

  logic rst_meta_n;
  logic rst_n;

  // Release through two flops so removal is clean
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Decode

  logic       is_direct;
  logic       is_indirect;
  logic       is_bit;
  logic       is_push;
  logic       is_pop;
  logic       in_sfs;
  logic [7:0] bit_reg_addr;
  logic [2:0] bit_pos;
  logic       bit_in_sfs;

  assign is_direct   = i_req.kind == sfsp_pkg::SFSP_REQ_DIRECT;
  assign is_indirect = i_req.kind == sfsp_pkg::SFSP_REQ_INDIRECT;
  assign is_bit      = i_req.kind == sfsp_pkg::SFSP_REQ_BIT;
  assign is_push     = i_req.kind == sfsp_pkg::SFSP_REQ_PUSH;
  assign is_pop      = i_req.kind == sfsp_pkg::SFSP_REQ_POP;

  // Direct addresses from the base up are special registers
  assign in_sfs = i_req.addr >= sfsp_pkg::SFS_BASE;

  // Bit address: in the upper half it names a column-aligned register
  assign bit_in_sfs   = i_req.addr >= sfsp_pkg::SFS_BASE;
  assign bit_reg_addr = bit_in_sfs ?
                        {i_req.addr[7:3], sfsp_pkg::COLUMN_ZERO} :
                        (sfsp_pkg::BIT_MEM_BASE + {4'h0, i_req.addr[6:3]});
  assign bit_pos      = i_req.addr[2:0];

  ////////////////////////////////////////////////////////////////////
  // Special register file

  logic [7:0] stack_top_pointer;
  logic [7:0] data_pointer_low;
  logic [7:0] data_pointer_high;
  logic [7:0] processor_status_flags;
  logic [7:0] arith_primary_reg;
  logic [7:0] arith_secondary_reg;

  logic       sfs_we;
  logic [7:0] sfs_waddr;
  logic [7:0] sfs_wdata;
  logic [7:0] sfs_rdata;
  logic       sfs_hit;
  logic [7:0] sfs_raddr;

  // Address used for the register read: byte or aligned bit register
  assign sfs_raddr = is_bit ? bit_reg_addr : i_req.addr;

  // Register read mux; reserved addresses read as zero
  always_comb begin
    sfs_hit   = 1'b1;
    sfs_rdata = sfsp_pkg::RD_RESERVED;
    case (sfs_raddr)
      sfsp_pkg::ADR_STACK_TOP: sfs_rdata = stack_top_pointer;
      sfsp_pkg::ADR_DPTR_LO:   sfs_rdata = data_pointer_low;
      sfsp_pkg::ADR_DPTR_HI:   sfs_rdata = data_pointer_high;
      sfsp_pkg::ADR_STATUS:    sfs_rdata = processor_status_flags;
      sfsp_pkg::ADR_ARITH_A:   sfs_rdata = arith_primary_reg;
      sfsp_pkg::ADR_ARITH_B:   sfs_rdata = arith_secondary_reg;
      default:                 sfs_hit   = 1'b0;
    endcase
  end

  // Write path: a bit write merges one bit into the current byte
  always_comb begin
    sfs_we    = 1'b0;
    sfs_waddr = i_req.addr;
    sfs_wdata = i_req.wdata;
    if (is_direct && i_req.write && in_sfs) begin
      sfs_we = 1'b1;
    end else if (is_bit && i_req.write && bit_in_sfs) begin
      sfs_we    = 1'b1;
      sfs_waddr = bit_reg_addr;
      sfs_wdata = sfs_rdata;
      sfs_wdata[bit_pos] = i_req.wbit;
    end
  end

  // Plain byte registers; the pointer is kept in its own process
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      data_pointer_low       <= sfsp_pkg::RST_DPTR_LO;
      data_pointer_high      <= sfsp_pkg::RST_DPTR_HI;
      processor_status_flags <= sfsp_pkg::RST_STATUS;
      arith_primary_reg      <= sfsp_pkg::RST_ARITH_A;
      arith_secondary_reg    <= sfsp_pkg::RST_ARITH_B;
    end else if (sfs_we) begin
      case (sfs_waddr)
        sfsp_pkg::ADR_DPTR_LO: data_pointer_low       <= sfs_wdata;
        sfsp_pkg::ADR_DPTR_HI: data_pointer_high      <= sfs_wdata;
        sfsp_pkg::ADR_STATUS:  processor_status_flags <= sfs_wdata;
        sfsp_pkg::ADR_ARITH_A: arith_primary_reg      <= sfs_wdata;
        sfsp_pkg::ADR_ARITH_B: arith_secondary_reg    <= sfs_wdata;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Stack pointer

  logic [7:0] next_stack_top_pointer;

  // Push pre-increments, pop post-decrements; 8 bits wrap over 256
  always_comb begin
    next_stack_top_pointer = stack_top_pointer;
    if (is_push) begin
      next_stack_top_pointer = stack_top_pointer + 8'h01;
    end else if (is_pop) begin
      next_stack_top_pointer = stack_top_pointer - 8'h01;
    end else if (sfs_we && sfs_waddr == sfsp_pkg::ADR_STACK_TOP) begin
      next_stack_top_pointer = sfs_wdata;
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      stack_top_pointer <= sfsp_pkg::RST_STACK_TOP;
    end else begin
      stack_top_pointer <= next_stack_top_pointer;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Data memory

  logic       mem_we;
  logic [7:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic [7:0] push_addr;

  assign push_addr = stack_top_pointer + 8'h01;

  // Memory address and write steering
  always_comb begin
    mem_we    = 1'b0;
    mem_addr  = i_req.addr;
    if (is_push) begin
      mem_we   = 1'b1;
      mem_addr = push_addr;
    end else if (is_pop) begin
      mem_addr = stack_top_pointer;
    end else if (is_indirect) begin
      mem_we = i_req.write;
    end else if (is_direct && !in_sfs) begin
      mem_we = i_req.write;
    end else if (is_bit && !bit_in_sfs) begin
      mem_addr  = bit_reg_addr;
      mem_we    = i_req.write;
    end
  end

  // Bit write merges into the byte read back; kept apart from the
  // address steering so the read port never feeds its own address
  always_comb begin
    mem_wdata = i_req.wdata;
    if (is_bit && !bit_in_sfs) begin
      mem_wdata          = mem_rdata;
      mem_wdata[bit_pos] = i_req.wbit;
    end
  end

  sfsp_data_mem #(
    .DEPTH (sfsp_pkg::MEM_DEPTH)
  ) u_mem (
    .i_clock (i_clock),
    .i_we    (mem_we),
    .i_waddr (mem_addr),
    .i_wdata (mem_wdata),
    .i_raddr (mem_addr),
    .o_rdata (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////
  // Answer

  logic [7:0] next_rdata;
  logic       next_rbit;
  logic       next_error;

  // Select read source by addressing mode
  always_comb begin
    next_rdata = mem_rdata;
    next_error = 1'b0;
    if (is_direct && in_sfs) begin
      next_rdata = sfs_rdata;
      next_error = !sfs_hit;
    end else if (is_bit && bit_in_sfs) begin
      next_rdata = sfs_rdata;
      next_error = !sfs_hit;
    end
    next_rbit = next_rdata[bit_pos];
  end

  // Answer is registered one cycle after the request
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_rsp          <= '0;
      o_access_error <= 1'b0;
    end else begin
      o_rsp.valid    <= i_req.kind != sfsp_pkg::SFSP_REQ_NONE;
      o_rsp.rdata    <= next_rdata;
      o_rsp.rbit     <= next_rbit;
      o_access_error <= next_error;
    end
  end

  assign o_stack_top_pointer      = stack_top_pointer;
  assign o_data_pointer           = {data_pointer_high, data_pointer_low};
  assign o_processor_status_flags = processor_status_flags;
  assign o_arith_primary_reg      = arith_primary_reg;
  assign o_arith_secondary_reg    = arith_secondary_reg;

  ////////////////////////////////////////////////////////////////////
  // Checks

  a_reset_pointer: assert property (@(posedge i_clock)
    $rose(rst_n) |-> stack_top_pointer == sfsp_pkg::RST_STACK_TOP)
    else $error("pointer not 0x07 after reset");

  a_push_step: assert property (@(posedge i_clock) disable iff (!rst_n)
    is_push |=> stack_top_pointer == $past(stack_top_pointer) + 8'h01)
    else $error("push did not increment pointer");

  a_push_target: assert property (@(posedge i_clock) disable iff (!rst_n)
    is_push |-> mem_we && mem_addr == stack_top_pointer + 8'h01)
    else $error("push wrote wrong address");

  a_pop_step: assert property (@(posedge i_clock) disable iff (!rst_n)
    is_pop |-> !mem_we && mem_addr == stack_top_pointer
    ##1 stack_top_pointer == $past(stack_top_pointer) - 8'h01)
    else $error("pop sequence wrong");

  a_direct_upper: assert property (@(posedge i_clock) disable iff (!rst_n)
    is_direct && in_sfs |-> !mem_we)
    else $error("direct upper access reached memory");

  a_direct_lower: assert property (@(posedge i_clock) disable iff (!rst_n)
    is_direct && !in_sfs |-> !sfs_we && mem_we == i_req.write)
    else $error("direct lower access misrouted");

  a_indirect_mem: assert property (@(posedge i_clock) disable iff (!rst_n)
    is_indirect && i_req.write |-> mem_we && !sfs_we && mem_addr == i_req.addr)
    else $error("indirect access misrouted");

  a_bit_column: assert property (@(posedge i_clock) disable iff (!rst_n)
    sfs_we && is_bit |-> sfs_waddr[2:0] == 3'h0)
    else $error("bit write off column");

  a_sp_write: assert property (@(posedge i_clock) disable iff (!rst_n)
    sfs_we && is_direct && i_req.addr == sfsp_pkg::ADR_STACK_TOP |=>
    stack_top_pointer == $past(i_req.wdata))
    else $error("pointer write lost");

endmodule : sfsp_space

// *** test/sfsp_core_model.sv ***
/*
  Behavioural model of the core that issues requests to the special
  function space block. Assumes the block answers on the edge that takes
  a request, one clock after the model drives it, as a single-cycle pulse.
*/
`timescale 1ns/1ns
module sfsp_core_model (
  // Clock
  input  wire logic                i_clock,
  // Answer from the block
  input  wire sfsp_pkg::sfsp_rsp_t i_rsp,
  input  wire logic                i_access_error,
  // Request to the block
  output sfsp_pkg::sfsp_req_t      o_req
);
  ////////////////////////////////////////////////////////////////////////////////
  // Idle at time zero, so nothing is taken before the bench calls in
  initial o_req = '0;

  ////////////////////////////////////////////////////////////////////////////////
  // One request per call; an idle cycle follows so no answer is missed
  task issue(input sfsp_pkg::sfsp_req_t r, output sfsp_pkg::sfsp_rsp_t rsp, output logic err);
    @(posedge i_clock);
    // Sends only what the caller asks: no reserved places or stack moves of its own
    o_req <= r;
    @(posedge i_clock);
    o_req <= '0;
    // Sample once the answering edge has settled
    #1;
    rsp = i_rsp;
    err = i_access_error;
  endtask : issue
endmodule : sfsp_core_model

// *** test/sfsp_space_test.sv ***
/*
  Self-checking bench for the special function space block: a table of
  requests with expected answers, then register views and a mid-run reset.
  Assumes the core model in its own file and the block's package.
*/
`timescale 1ns/1ns
module sfsp_space_test;
  typedef struct packed {
    sfsp_pkg::sfsp_req_t req;
    logic [7:0]          rd;
    logic                rb;
    logic                err;
    logic [1:0]          chk;
  } sfsp_row_t;
  localparam sfsp_pkg::sfsp_kind_t KD = sfsp_pkg::SFSP_REQ_DIRECT;
  localparam sfsp_pkg::sfsp_kind_t KI = sfsp_pkg::SFSP_REQ_INDIRECT;
  localparam sfsp_pkg::sfsp_kind_t KB = sfsp_pkg::SFSP_REQ_BIT;
  localparam sfsp_pkg::sfsp_kind_t KU = sfsp_pkg::SFSP_REQ_PUSH;
  localparam sfsp_pkg::sfsp_kind_t KO = sfsp_pkg::SFSP_REQ_POP;

  logic                i_clock;
  logic                i_nrst;
  sfsp_pkg::sfsp_req_t req;
  sfsp_pkg::sfsp_rsp_t rsp;
  logic [7:0]          stack_view;
  logic [15:0]         dptr;
  logic [7:0]          status_view;
  logic [7:0]          arith_a_view;
  logic [7:0]          regb;
  logic                aerr;
  int                  n_errors;
  int                  comparisons;
  sfsp_row_t           rows [31];

  ////////////////////////////////////////////////////////////////////////////////
  // Block and core model
  sfsp_space sfsp_space_inst (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_req(req), .o_rsp(rsp),
    .o_stack_top_pointer(stack_view), .o_data_pointer(dptr),
    .o_processor_status_flags(status_view), .o_arith_primary_reg(arith_a_view),
    .o_arith_secondary_reg(regb), .o_access_error(aerr)
  );
  sfsp_core_model sfsp_core_model_inst (
    .i_clock(i_clock), .i_rsp(rsp), .i_access_error(aerr), .o_req(req)
  );

  // 100 ns period clock
  initial i_clock = 1'b0;
  always #50 i_clock = ~i_clock;

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, count, report
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task complete_run;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  function automatic sfsp_row_t mk(sfsp_pkg::sfsp_kind_t k, logic w, logic [7:0] a,
                                   logic [7:0] wd, logic wb, logic [7:0] rd, logic rb,
                                   logic e, logic [1:0] c);
    return '{req: '{kind: k, write: w, addr: a, wdata: wd, wbit: wb},
             rd: rd, rb: rb, err: e, chk: c};
  endfunction : mk

  // Chk 1 compares read data, 2 compares the read bit
  task run_row(input sfsp_row_t r);
    sfsp_pkg::sfsp_rsp_t s;
    logic                e;
    sfsp_core_model_inst.issue(r.req, s, e);
    check("valid", {15'h0000, s.valid}, 16'h0001);
    check("access error", {15'h0000, e}, {15'h0000, r.err});
    if (r.chk == 2'h1) check("rdata", {8'h00, s.rdata}, {8'h00, r.rd});
    if (r.chk == 2'h2) check("rbit", {15'h0000, s.rbit}, {15'h0000, r.rb});
  endtask : run_row

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well above the expected run
  initial begin
    #(100 * 3000);
    n_errors++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    n_errors = 0;
    comparisons = 0;
    i_nrst = 1'b0;
    rows[0]  = mk(KD, 1'b0, 8'h81, 8'h00, 1'b0, 8'h07, 1'b0, 1'b0, 2'h1);
    rows[1]  = mk(KU, 1'b1, 8'h00, 8'hA5, 1'b0, 8'h00, 1'b0, 1'b0, 2'h0);
    rows[2]  = mk(KD, 1'b0, 8'h81, 8'h00, 1'b0, 8'h08, 1'b0, 1'b0, 2'h1);
    rows[3]  = mk(KI, 1'b0, 8'h08, 8'h00, 1'b0, 8'hA5, 1'b0, 1'b0, 2'h1);
    rows[4]  = mk(KD, 1'b0, 8'h08, 8'h00, 1'b0, 8'hA5, 1'b0, 1'b0, 2'h1);
    rows[5]  = mk(KD, 1'b1, 8'hE0, 8'h3C, 1'b0, 8'h00, 1'b0, 1'b0, 2'h0);
    rows[6]  = mk(KI, 1'b1, 8'hE0, 8'h77, 1'b0, 8'h00, 1'b0, 1'b0, 2'h0);
    rows[7]  = mk(KD, 1'b0, 8'hE0, 8'h00, 1'b0, 8'h3C, 1'b0, 1'b0, 2'h1);
    rows[8]  = mk(KI, 1'b0, 8'hE0, 8'h00, 1'b0, 8'h77, 1'b0, 1'b0, 2'h1);
    rows[9]  = mk(KB, 1'b1, 8'hE1, 8'h00, 1'b1, 8'h00, 1'b0, 1'b0, 2'h0);
    rows[10] = mk(KD, 1'b0, 8'hE0, 8'h00, 1'b0, 8'h3E, 1'b0, 1'b0, 2'h1);
    rows[11] = mk(KB, 1'b0, 8'hE2, 8'h00, 1'b0, 8'h00, 1'b1, 1'b0, 2'h2);
    rows[12] = mk(KB, 1'b1, 8'hF7, 8'h00, 1'b1, 8'h00, 1'b0, 1'b0, 2'h0);
    rows[13] = mk(KB, 1'b1, 8'h81, 8'h00, 1'b0, 8'h00, 1'b0, 1'b1, 2'h0);
    rows[14] = mk(KD, 1'b0, 8'h81, 8'h00, 1'b0, 8'h08, 1'b0, 1'b0, 2'h1);
    rows[15] = mk(KD, 1'b0, 8'h84, 8'h00, 1'b0, 8'h00, 1'b0, 1'b1, 2'h1);
    rows[16] = mk(KO, 1'b0, 8'h00, 8'h00, 1'b0, 8'hA5, 1'b0, 1'b0, 2'h1);
    rows[17] = mk(KD, 1'b0, 8'h81, 8'h00, 1'b0, 8'h07, 1'b0, 1'b0, 2'h1);
    rows[18] = mk(KD, 1'b1, 8'h81, 8'hFE, 1'b0, 8'h00, 1'b0, 1'b0, 2'h0);
    rows[19] = mk(KU, 1'b1, 8'h00, 8'h11, 1'b0, 8'h00, 1'b0, 1'b0, 2'h0);
    rows[20] = mk(KU, 1'b1, 8'h00, 8'h22, 1'b0, 8'h00, 1'b0, 1'b0, 2'h0);
    rows[21] = mk(KD, 1'b0, 8'h81, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0, 2'h1);
    rows[22] = mk(KI, 1'b0, 8'hFF, 8'h00, 1'b0, 8'h11, 1'b0, 1'b0, 2'h1);
    rows[23] = mk(KI, 1'b0, 8'h00, 8'h00, 1'b0, 8'h22, 1'b0, 1'b0, 2'h1);
    rows[24] = mk(KD, 1'b1, 8'h82, 8'h12, 1'b0, 8'h00, 1'b0, 1'b0, 2'h0);
    rows[25] = mk(KD, 1'b1, 8'h83, 8'h34, 1'b0, 8'h00, 1'b0, 1'b0, 2'h0);
    rows[26] = mk(KD, 1'b1, 8'hD0, 8'h5A, 1'b0, 8'h00, 1'b0, 1'b0, 2'h0);
    rows[27] = mk(KB, 1'b1, 8'hD3, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0, 2'h0);
    rows[28] = mk(KI, 1'b1, 8'h21, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0, 2'h0);
    rows[29] = mk(KB, 1'b1, 8'h0B, 8'h00, 1'b1, 8'h00, 1'b0, 1'b0, 2'h0);
    rows[30] = mk(KD, 1'b0, 8'h21, 8'h00, 1'b0, 8'h08, 1'b0, 1'b0, 2'h1);
    repeat (20) @(posedge i_clock);
    i_nrst <= 1'b1;
    // Internal reset copy needs two edges before requests are taken
    repeat (3) @(posedge i_clock);
    foreach (rows[i]) run_row(rows[i]);
    // Register views after the table
    check("data pointer", dptr, 16'h3412);
    check("status", {8'h00, status_view}, 16'h0052);
    check("arith a", {8'h00, arith_a_view}, 16'h003E);
    check("b reg", {8'h00, regb}, 16'h0080);
    check("stack pointer", {8'h00, stack_view}, 16'h0000);
    // Reset in mid-run reloads the pointer and clears the others
    @(posedge i_clock);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clock);
    check("reset pointer", {8'h00, stack_view}, 16'h0007);
    check("reset dptr", dptr, 16'h0000);
    check("reset arith a", {8'h00, arith_a_view}, 16'h0000);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_clock);
    // First push after reset lands at 0x08
    run_row(mk(KU, 1'b1, 8'h00, 8'h9C, 1'b0, 8'h00, 1'b0, 1'b0, 2'h0));
    check("push pointer", {8'h00, stack_view}, 16'h0008);
    run_row(mk(KI, 1'b0, 8'h08, 8'h00, 1'b0, 8'h9C, 1'b0, 1'b0, 2'h1));
    complete_run();
  end
endmodule : sfsp_space_test
